// *** rtl/cdr_port_cfg.svh ***
// register offsets, field positions, reset values and lock thresholds of the cdr register port
// assumes it is included by its bare name wherever the constants are needed
`ifndef CDR_PORT_CFG_SVH
`define CDR_PORT_CFG_SVH

// ****************************************
// sub-addresses
// ****************************************
`define CDR_SUB_FREQ_LOW 8'h00
`define CDR_SUB_FREQ_MID 8'h01
`define CDR_SUB_FREQ_HIGH 8'h02
`define CDR_SUB_STATUS 8'h04
`define CDR_SUB_RATE_REF 8'h08
`define CDR_SUB_LOCK_RST 8'h09
`define CDR_SUB_OUTPUT 8'h11

// ****************************************
// reset values and write masks
// ****************************************
`define CDR_CTRL_RESET 8'h00
`define CDR_LOCK_RST_WMASK 8'he8
`define CDR_OUTPUT_WMASK 8'h07

// ****************************************
// field positions
// ****************************************
`define CDR_RR_LOCK_REF 0
`define CDR_RR_MEASURE 1
`define CDR_RR_RATIO_LSB 2
`define CDR_RR_BAND_LSB 6
`define CDR_LR_PIN_SEL 7
`define CDR_LR_CLR_LATCH 6
`define CDR_LR_SYS_RST 5
`define CDR_LR_CLR_DONE 3
`define CDR_OC_LOS_POL 2
`define CDR_OC_SQ_MODE 1
`define CDR_OC_BOOST 0
`define CDR_ST_LOS 5
`define CDR_ST_LATCH 4
`define CDR_ST_LOL 3
`define CDR_ST_DONE 2

// ****************************************
// lock detector thresholds in ppm
// ****************************************
`define CDR_LOL_SET_PPM 16'h03e8
`define CDR_LOL_CLR_PPM 16'h00fa

`endif

// *** rtl/cdr_port_pkg.sv ***
// types shared by the cdr register port and its write-pair detector
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package cdr_port_pkg;

  typedef enum logic [3:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_ADDR_ACK,
    BUS_SUB,
    BUS_SUB_ACK,
    BUS_WDATA,
    BUS_WDATA_ACK,
    BUS_RDATA,
    BUS_RACK
  } bus_state_e;

  // controls handed to the analog side, all registered
  typedef struct packed {
    logic [1:0] reference_band_select;
    logic [3:0] ratio;
    logic lock_to_ref;
    logic measure_start;
    logic signal_lost_pin;
    logic lock_lost_pin;
    logic clk_out_en;
    logic data_out_en;
    logic boost;
  } cdr_ctrl_s;

  typedef struct packed {
    bus_state_e st;
    logic scl_q;
    logic sda_q;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] sub;
    logic rw;
    logic mack;
    logic sda_oe;
    logic [7:0] rate_ref_control;
    logic [7:0] lock_reset_control;
    logic [7:0] output_control;
    logic lock_lost;
    logic latched_lock_lost;
    logic busy;
    logic done;
    logic [22:0] freq;
    cdr_ctrl_s pins;
  } port_state_s;

  typedef struct packed {
    logic armed;
    logic fire;
  } pair_state_s;

endpackage : cdr_port_pkg
`default_nettype wire

// *** rtl/write_pair_detect.sv ***
// detects a write of 1 followed by a write of 0 to one control bit
// assumes WR is a one-cycle strobe qualified by CE
`timescale 1ns/1ps
`default_nettype none
module write_pair_detect (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic WR,
  input wire logic BIT,
  output logic FIRE
);
  import cdr_port_pkg::*;

  pair_state_s s_reg;
  pair_state_s s_next;

  // ****************************************
  // sequence
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.fire = 1'b0;
    if (WR) begin
      if (BIT) begin
        s_next.armed = 1'b1;
      end else begin
        // a lone 0 write does nothing; the 1 must come first
        s_next.fire = s_reg.armed;
        s_next.armed = 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      s_reg <= '0;
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  assign FIRE = s_reg.fire;

  chk_pair_fires: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CE && WR && !BIT && s_reg.armed |=> FIRE)
    else $error("write pair did not fire");

endmodule : write_pair_detect
`default_nettype wire

// *** rtl/cdr_register_port.sv ***
// two-wire slave port and control/status registers of the clock and data recovery receiver
// assumes scl and sda are already synchronous to REF_CLK and sda is open drain outside
`timescale 1ns/1ps
`default_nettype none
`include "cdr_port_cfg.svh"

// Behaviour
// - write: start, address with bit 0, sub-address, data bytes, each acked, stop
// - read: address and sub-address, repeated start with bit 1, slave sends bytes
// - every writable control register is 0x00 after reset until written
// - status bit 5 reads 1 while signal is lost
// - status bit 4 is a sticky lock-lost flag held until cleared
// - status bit 3 reads 0 when locked, 1 while acquiring
// - status bit 2 is 0 while measuring, 1 when complete, held until cleared
// - writing 1 to control bit 1 starts a data-rate measurement
// - control bit 0 selects lock to data (0) or to reference (1)
// - bits 7:6 pick the reference band, bits 5:2 the reference ratio
// - lock pin follows live loss of lock or the sticky flag per bit 7
// - writing 1 then 0 to bit 6 clears status bit 4
// - writing 1 then 0 to bit 3 clears status bit 2
// - writing 1 then 0 to bit 5 resets the device; unused bits are 0
// - third register bit 2 sets signal-lost pin polarity, upper bits ignored
// - squelch mode 0 silences data and clock, mode 1 silences data only
// - third register bit 0 selects default or boosted output swing
// - loss of lock set beyond 1000 ppm, cleared within 250 ppm
// - squelch input is active high and gates the outputs
module cdr_register_port #(
  parameter logic [6:0] SLAVE_ADDR = 7'h40
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic SCK_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic SADDR5_IN,
  input wire logic SIGNAL_LOST_IN,
  input wire logic [15:0] FREQ_DIFF_PPM,
  input wire logic MEAS_DONE_IN,
  input wire logic [22:0] MEAS_RESULT_IN,
  input wire logic SQUELCH_IN,
  output cdr_port_pkg::cdr_ctrl_s CDR_CTRL
);
  import cdr_port_pkg::*;

  port_state_s s_reg;
  port_state_s s_next;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic wr_en;
  logic [7:0] rd_first;
  logic [7:0] rd_next;
  logic wr_lock_rst;
  logic clr_latch_fire;
  logic clr_done_fire;
  logic sys_rst_fire;
  logic [6:0] my_addr;

  assign my_addr = {SLAVE_ADDR[6], SADDR5_IN, SLAVE_ADDR[4:0]};

  // ****************************************
  // read mux
  // ****************************************
  function automatic logic [7:0] rd_byte(input logic [7:0] sub, input port_state_s st,
                                         input logic signal_lost);
    logic [7:0] v;
    v = 8'h00;
    case (sub)
      `CDR_SUB_FREQ_LOW: v = st.freq[7:0];
      `CDR_SUB_FREQ_MID: v = st.freq[15:8];
      `CDR_SUB_FREQ_HIGH: v = {1'b0, st.freq[22:16]};
      `CDR_SUB_STATUS: begin
        v[`CDR_ST_LOS] = signal_lost;
        v[`CDR_ST_LATCH] = st.latched_lock_lost;
        v[`CDR_ST_LOL] = st.lock_lost;
        v[`CDR_ST_DONE] = st.done;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_byte

  assign rd_first = rd_byte(s_reg.sub, s_reg, SIGNAL_LOST_IN);
  assign rd_next = rd_byte(s_reg.sub + 8'h01, s_reg, SIGNAL_LOST_IN);
  assign wr_lock_rst = wr_en && (s_reg.sub == `CDR_SUB_LOCK_RST);

  // ****************************************
  // clear and reset sequences
  // ****************************************
  write_pair_detect u_clr_latch (
    .REF_CLK(REF_CLK),
    .RST_N(RST_N),
    .CE(CE),
    .WR(wr_lock_rst),
    .BIT(s_reg.shreg[`CDR_LR_CLR_LATCH]),
    .FIRE(clr_latch_fire)
  );

  write_pair_detect u_clr_done (
    .REF_CLK(REF_CLK),
    .RST_N(RST_N),
    .CE(CE),
    .WR(wr_lock_rst),
    .BIT(s_reg.shreg[`CDR_LR_CLR_DONE]),
    .FIRE(clr_done_fire)
  );

  write_pair_detect u_sys_rst (
    .REF_CLK(REF_CLK),
    .RST_N(RST_N),
    .CE(CE),
    .WR(wr_lock_rst),
    .BIT(s_reg.shreg[`CDR_LR_SYS_RST]),
    .FIRE(sys_rst_fire)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.scl_q = SCK_IN;
    s_next.sda_q = SDA_IN;
    scl_rise = SCK_IN && !s_reg.scl_q;
    scl_fall = !SCK_IN && s_reg.scl_q;
    start_seen = SCK_IN && s_reg.scl_q && s_reg.sda_q && !SDA_IN;
    stop_seen = SCK_IN && s_reg.scl_q && !s_reg.sda_q && SDA_IN;
    wr_en = 1'b0;
    s_next.pins.measure_start = 1'b0;

    case (s_reg.st)
      BUS_IDLE: begin
        s_next.sda_oe = 1'b0;
      end
      BUS_ADDR, BUS_SUB, BUS_WDATA: begin
        if (scl_rise) begin
          s_next.shreg = {s_reg.shreg[6:0], SDA_IN};
          s_next.bitcnt = s_reg.bitcnt + 4'h1;
        end else if (scl_fall && s_reg.bitcnt == 4'h8) begin
          // sub-address and data bytes are acked, whatever the sub-address; the address byte only on a match
          s_next.bitcnt = 4'h0;
          s_next.sda_oe = 1'b1;
          if (s_reg.st == BUS_ADDR) begin
            if (s_reg.shreg[7:1] == my_addr) begin
              s_next.rw = s_reg.shreg[0];
              s_next.st = BUS_ADDR_ACK;
            end else begin
              s_next.sda_oe = 1'b0;
              s_next.st = BUS_IDLE;
            end
          end else if (s_reg.st == BUS_SUB) begin
            s_next.sub = s_reg.shreg;
            s_next.st = BUS_SUB_ACK;
          end else begin
            wr_en = 1'b1;
            s_next.sub = s_reg.sub + 8'h01;
            s_next.st = BUS_WDATA_ACK;
          end
        end
      end
      BUS_ADDR_ACK, BUS_SUB_ACK, BUS_WDATA_ACK: begin
        if (scl_fall) begin
          s_next.sda_oe = 1'b0;
          if (s_reg.st == BUS_ADDR_ACK && s_reg.rw) begin
            s_next.shreg = rd_first;
            s_next.sda_oe = !rd_first[7];
            s_next.st = BUS_RDATA;
          end else if (s_reg.st == BUS_ADDR_ACK) begin
            s_next.st = BUS_SUB;
          end else begin
            s_next.st = BUS_WDATA;
          end
        end
      end
      BUS_RDATA: begin
        if (scl_rise) begin
          s_next.bitcnt = s_reg.bitcnt + 4'h1;
        end else if (scl_fall) begin
          if (s_reg.bitcnt == 4'h8) begin
            s_next.sda_oe = 1'b0;
            s_next.bitcnt = 4'h0;
            s_next.st = BUS_RACK;
          end else begin
            s_next.shreg = {s_reg.shreg[6:0], 1'b0};
            s_next.sda_oe = !s_reg.shreg[6];
          end
        end
      end
      BUS_RACK: begin
        if (scl_rise) begin
          s_next.mack = !SDA_IN;
        end else if (scl_fall) begin
          s_next.sub = s_reg.sub + 8'h01;
          if (s_reg.mack) begin
            s_next.shreg = rd_next;
            s_next.sda_oe = !rd_next[7];
            s_next.st = BUS_RDATA;
          end else begin
            // master said no more; wait for its stop or start
            s_next.st = BUS_IDLE;
          end
        end
      end
      default: begin
        s_next.st = BUS_IDLE;
      end
    endcase

    if (start_seen) begin
      s_next.st = BUS_ADDR;
      s_next.bitcnt = 4'h0;
      s_next.sda_oe = 1'b0;
    end else if (stop_seen) begin
      s_next.st = BUS_IDLE;
      s_next.sda_oe = 1'b0;
    end

    // register writes; reserved bits and unknown sub-addresses are dropped
    if (wr_en) begin
      case (s_reg.sub)
        `CDR_SUB_RATE_REF: begin
          s_next.rate_ref_control = s_reg.shreg;
          if (s_reg.shreg[`CDR_RR_MEASURE]) begin
            s_next.busy = 1'b1;
            s_next.done = 1'b0;
            s_next.pins.measure_start = 1'b1;
          end
        end
        `CDR_SUB_LOCK_RST: s_next.lock_reset_control = s_reg.shreg & `CDR_LOCK_RST_WMASK;
        `CDR_SUB_OUTPUT: s_next.output_control = s_reg.shreg & `CDR_OUTPUT_WMASK;
        default: s_next.busy = s_next.busy;
      endcase
    end

    // measurement; the clear is applied first so a completion in the same cycle wins
    if (clr_done_fire) begin
      s_next.done = 1'b0;
    end
    if (s_reg.busy && MEAS_DONE_IN) begin
      s_next.freq = MEAS_RESULT_IN;
      s_next.busy = 1'b0;
      s_next.done = 1'b1;
    end

    // lock detector with hysteresis between the two thresholds
    if (FREQ_DIFF_PPM > `CDR_LOL_SET_PPM) begin
      s_next.lock_lost = 1'b1;
    end else if (FREQ_DIFF_PPM <= `CDR_LOL_CLR_PPM) begin
      s_next.lock_lost = 1'b0;
    end
    if (clr_latch_fire) begin
      s_next.latched_lock_lost = 1'b0;
    end
    if (s_next.lock_lost) begin
      s_next.latched_lock_lost = 1'b1;
    end

    // soft reset leaves the bus engine alone so the ack of the write completes
    if (sys_rst_fire) begin
      s_next.rate_ref_control = `CDR_CTRL_RESET;
      s_next.lock_reset_control = `CDR_CTRL_RESET;
      s_next.output_control = `CDR_CTRL_RESET;
      s_next.lock_lost = 1'b0;
      s_next.latched_lock_lost = 1'b0;
      s_next.busy = 1'b0;
      s_next.done = 1'b0;
      s_next.freq = '0;
    end

    // ****************************************
    // pins, from the new register values
    // ****************************************
    s_next.pins.reference_band_select = s_next.rate_ref_control[`CDR_RR_BAND_LSB +: 2];
    s_next.pins.ratio = s_next.rate_ref_control[`CDR_RR_RATIO_LSB +: 4];
    s_next.pins.lock_to_ref = s_next.rate_ref_control[`CDR_RR_LOCK_REF];
    s_next.pins.signal_lost_pin = SIGNAL_LOST_IN ^ s_next.output_control[`CDR_OC_LOS_POL];
    s_next.pins.lock_lost_pin = s_next.lock_reset_control[`CDR_LR_PIN_SEL] ?
                                s_next.latched_lock_lost : s_next.lock_lost;
    s_next.pins.data_out_en = !SQUELCH_IN;
    s_next.pins.clk_out_en = !(SQUELCH_IN && !s_next.output_control[`CDR_OC_SQ_MODE]);
    s_next.pins.boost = s_next.output_control[`CDR_OC_BOOST];
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      s_reg <= '0;
      s_reg.st <= BUS_IDLE;
      s_reg.scl_q <= 1'b1;
      s_reg.sda_q <= 1'b1;
      s_reg.pins.clk_out_en <= 1'b1;
      s_reg.pins.data_out_en <= 1'b1;
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE = s_reg.sda_oe;
  assign CDR_CTRL = s_reg.pins;

  // ****************************************
  // checks
  // ****************************************
  chk_ctrl_reset_zero: assert property (@(posedge REF_CLK)
    $rose(RST_N) |-> s_reg.rate_ref_control == 8'h00 && s_reg.lock_reset_control == 8'h00 &&
    s_reg.output_control == 8'h00)
    else $error("control register not zero after reset");

  chk_sub_ack_driven: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    s_reg.st == BUS_SUB_ACK |-> SDA_OE)
    else $error("sub-address byte not acked");

  chk_latch_holds: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    s_reg.latched_lock_lost && !clr_latch_fire && !sys_rst_fire |=> s_reg.latched_lock_lost)
    else $error("sticky lock-lost flag dropped");

  chk_lol_set_limit: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CE && FREQ_DIFF_PPM > 16'h03e8 && !sys_rst_fire |=> s_reg.lock_lost && s_reg.latched_lock_lost)
    else $error("loss of lock not raised above limit");

  chk_lol_clr_limit: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CE && FREQ_DIFF_PPM <= 16'h00fa |=> !s_reg.lock_lost)
    else $error("loss of lock not cleared within limit");

  chk_meas_complete: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CE && s_reg.busy && MEAS_DONE_IN && !sys_rst_fire |=>
    s_reg.done && !s_reg.busy && s_reg.freq == $past(MEAS_RESULT_IN))
    else $error("measurement completion not recorded");

  chk_meas_start: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CE && wr_en && s_reg.sub == `CDR_SUB_RATE_REF && s_reg.shreg[`CDR_RR_MEASURE] && !sys_rst_fire
    |=> CDR_CTRL.measure_start && s_reg.busy && !s_reg.done ##1 !CDR_CTRL.measure_start || !CE)
    else $error("measurement start not issued");

  chk_squelch_both: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CE && SQUELCH_IN && !s_next.output_control[`CDR_OC_SQ_MODE] |=>
    !CDR_CTRL.clk_out_en && !CDR_CTRL.data_out_en)
    else $error("squelch left an output running");

  chk_lock_pin_src: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CE |=> CDR_CTRL.lock_lost_pin == (s_reg.lock_reset_control[7] ?
    s_reg.latched_lock_lost : s_reg.lock_lost))
    else $error("lock pin shows wrong source");

  chk_los_pin_pol: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CE |=> CDR_CTRL.signal_lost_pin == (s_reg.output_control[2] ^ $past(SIGNAL_LOST_IN)))
    else $error("signal-lost pin polarity wrong");

endmodule : cdr_register_port
`default_nettype wire

// *** tb/i2c_host_model.sv ***
// behavioural two-wire bus master that drives the cdr register port
// assumes SDA_LINE is the resolved wire with a pull-up and that REF_CLK is the system clock
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
  parameter int QTR = 4
) (
  input wire logic REF_CLK,
  input wire logic SDA_LINE,
  output logic SCL,
  output logic SDA_LOW
);
  // ****************************************
  // bus phases
  // ****************************************
  // a quarter bit of QTR clocks keeps line changes well apart, the port
  // edge-detects on its previous sample
  initial begin
    SCL = 1'b1;
    SDA_LOW = 1'b0;
  end

  task automatic tick();
    repeat (QTR) @(negedge REF_CLK);
  endtask : tick

  task automatic start_cond();
    SDA_LOW = 1'b0;
    tick();
    SCL = 1'b1;
    tick();
    SDA_LOW = 1'b1;
    tick();
    SCL = 1'b0;
    tick();
  endtask : start_cond

  task automatic stop_cond();
    SDA_LOW = 1'b1;
    tick();
    SCL = 1'b1;
    tick();
    SDA_LOW = 1'b0;
    tick();
  endtask : stop_cond

  task automatic xfer_bit(input logic b, output logic r);
    SDA_LOW = ~b;
    tick();
    SCL = 1'b1;
    tick();
    r = SDA_LINE;
    tick();
    SCL = 1'b0;
    tick();
  endtask : xfer_bit

  // last=1 releases the ninth bit, so a slave ack shows as a low line
  task automatic xfer_byte(input logic [7:0] d, input logic last, output logic [7:0] r,
                           output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], b);
      r[i] = b;
    end
    xfer_bit(last, b);
    ack = ~b;
  endtask : xfer_byte

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] sub,
                           input logic [7:0] val, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2;
    start_cond();
    xfer_byte({dev, 1'b0}, 1'b1, r, a0);
    xfer_byte(sub, 1'b1, r, a1);
    xfer_byte(val, 1'b1, r, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask : write_reg

  // bytes come back low first; every byte but the last is acked by the master
  task automatic read_regs(input logic [6:0] dev, input logic [7:0] sub, input int n,
                           output logic [23:0] val, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2, ak;
    val = '0;
    start_cond();
    xfer_byte({dev, 1'b0}, 1'b1, r, a0);
    xfer_byte(sub, 1'b1, r, a1);
    start_cond();
    xfer_byte({dev, 1'b1}, 1'b1, r, a2);
    for (int k = 0; k < n; k++) begin
      xfer_byte(8'hff, k == n - 1, r, ak);
      val[8*k +: 8] = r;
    end
    stop_cond();
    ok = a0 & a1 & a2;
  endtask : read_regs
endmodule : i2c_host_model
`default_nettype wire

// *** tb/cdr_i2c_register_port_test.sv ***
// self-checking bench for the cdr register port, driven through the two-wire bus
// assumes the port package, the cfg header and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "cdr_port_cfg.svh"
module cdr_i2c_register_port_test;
  import cdr_port_pkg::*;
  localparam logic [6:0] DEV = 7'h60; // default address with bit 5 from the pin
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sq = 1'b0;
  logic ce = 1'b1;
  logic signal_lost = 1'b0;
  logic [15:0] ppm = 16'h0000;
  logic mdone = 1'b0;
  logic [22:0] mres = 23'h000000;
  logic sda_oe, sda_out, scl, m_low, sda_wire, ok;
  cdr_ctrl_s ctrl, exp_c;
  int n_fail = 0;
  int checked = 0;
  int n_meas = 0;

  // ****************************************
  // clock, wire and design
  // ****************************************
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  assign sda_wire = ~(m_low | (sda_oe & ~sda_out));

  cdr_register_port dut (
    .REF_CLK(ref_clk), .RST_N(rst_n), .CE(ce), .SCK_IN(scl), .SDA_IN(sda_wire),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SADDR5_IN(1'b1), .SIGNAL_LOST_IN(signal_lost),
    .FREQ_DIFF_PPM(ppm), .MEAS_DONE_IN(mdone), .MEAS_RESULT_IN(mres),
    .SQUELCH_IN(sq), .CDR_CTRL(ctrl));
  i2c_host_model host (.REF_CLK(ref_clk), .SDA_LINE(sda_wire), .SCL(scl), .SDA_LOW(m_low));

  // counted away from the edge that launches the pulse
  always @(negedge ref_clk) begin
    if (ctrl.measure_start === 1'b1) begin
      n_meas <= n_meas + 1;
    end
  end

  // ****************************************
  // compares and bus helpers
  // ****************************************
  task automatic check_bit(input string what, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %b, seen %b", what, e, g);
    end
  endtask : check_bit

  task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : check_byte

  task automatic check_ctrl(input string what, input cdr_ctrl_s e);
    checked++;
    if (ctrl !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, e, ctrl);
    end
  endtask : check_ctrl

  task automatic settle();
    repeat (4) @(negedge ref_clk);
  endtask : settle

  task automatic write_chk(input logic [7:0] sub, input logic [7:0] val);
    logic a;
    host.write_reg(DEV, sub, val, a);
    check_bit("write ack", 1'b1, a);
    settle();
  endtask : write_chk

  task automatic read_n(input logic [7:0] sub, input int n, input logic [23:0] e);
    logic [23:0] v;
    logic a;
    host.read_regs(DEV, sub, n, v, a);
    check_bit("read ack", 1'b1, a);
    for (int k = 0; k < n; k++) begin
      check_byte("read byte", e[8*k +: 8], v[8*k +: 8]);
    end
  endtask : read_n

  task automatic status_is(input logic s5, input logic s4, input logic s3, input logic s2);
    read_n(`CDR_SUB_STATUS, 1, {16'h0000, 2'b00, s5, s4, s3, s2, 2'b00});
  endtask : status_is

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    exp_c = '0;
    exp_c.clk_out_en = 1'b1;
    exp_c.data_out_en = 1'b1;
    settle();
    check_ctrl("reset outputs", exp_c);
    read_n(`CDR_SUB_RATE_REF, 1, 24'h0);
    read_n(`CDR_SUB_LOCK_RST, 1, 24'h0);
    read_n(`CDR_SUB_OUTPUT, 1, 24'h0);
    status_is(1'b0, 1'b0, 1'b0, 1'b0);
    for (int b = 0; b < 4; b++) begin
      write_chk(`CDR_SUB_RATE_REF, {b[1:0], 4'b0101, 1'b0, b[0]});
      exp_c.reference_band_select = b[1:0];
      exp_c.ratio = 4'b0101;
      exp_c.lock_to_ref = b[0];
      check_ctrl("band and ratio", exp_c);
    end
    // measurement: start, result, then the 1-then-0 clear
    write_chk(`CDR_SUB_RATE_REF, 8'hd6);
    exp_c.lock_to_ref = 1'b0;
    check_bit("measure pulses", 1'b1, n_meas == 1);
    status_is(1'b0, 1'b0, 1'b0, 1'b0);
    mres = 23'h7a5c3e;
    mdone = 1'b1;
    @(negedge ref_clk);
    mdone = 1'b0;
    read_n(`CDR_SUB_FREQ_LOW, 3, 24'h7a5c3e);
    status_is(1'b0, 1'b0, 1'b0, 1'b1);
    write_chk(`CDR_SUB_LOCK_RST, 8'h08);
    status_is(1'b0, 1'b0, 1'b0, 1'b1);
    write_chk(`CDR_SUB_LOCK_RST, 8'h00);
    status_is(1'b0, 1'b0, 1'b0, 1'b0);
    // lock detector thresholds and the sticky flag
    ppm = 16'h03e8;
    status_is(1'b0, 1'b0, 1'b0, 1'b0);
    ppm = 16'h03e9;
    settle();
    exp_c.lock_lost_pin = 1'b1;
    check_ctrl("live lock pin", exp_c);
    ppm = 16'h00fb;
    status_is(1'b0, 1'b1, 1'b1, 1'b0);
    ppm = 16'h00fa;
    settle();
    exp_c.lock_lost_pin = 1'b0;
    check_ctrl("lock regained", exp_c);
    status_is(1'b0, 1'b1, 1'b0, 1'b0);
    write_chk(`CDR_SUB_LOCK_RST, 8'h80);
    exp_c.lock_lost_pin = 1'b1;
    check_ctrl("sticky lock pin", exp_c);
    write_chk(`CDR_SUB_LOCK_RST, 8'hc0);
    write_chk(`CDR_SUB_LOCK_RST, 8'h80);
    exp_c.lock_lost_pin = 1'b0;
    check_ctrl("sticky cleared", exp_c);
    status_is(1'b0, 1'b0, 1'b0, 1'b0);
    // output control: polarity, boost, squelch modes
    signal_lost = 1'b1;
    write_chk(`CDR_SUB_OUTPUT, 8'h05);
    exp_c.boost = 1'b1;
    check_ctrl("low polarity, boost", exp_c);
    status_is(1'b1, 1'b0, 1'b0, 1'b0);
    sq = 1'b1;
    settle();
    exp_c.clk_out_en = 1'b0;
    exp_c.data_out_en = 1'b0;
    check_ctrl("squelch both", exp_c);
    write_chk(`CDR_SUB_OUTPUT, 8'h02);
    exp_c.clk_out_en = 1'b1;
    exp_c.boost = 1'b0;
    exp_c.signal_lost_pin = 1'b1;
    check_ctrl("squelch data only", exp_c);
    sq = 1'b0;
    settle();
    exp_c.data_out_en = 1'b1;
    check_ctrl("squelch off", exp_c);
    // enable low freezes the lock detector; the miss only shows once it runs again
    ce = 1'b0;
    ppm = 16'h03e9;
    settle();
    check_ctrl("frozen by enable", exp_c);
    ce = 1'b1;
    settle();
    exp_c.lock_lost_pin = 1'b1;
    check_ctrl("enable resumed", exp_c);
    ppm = 16'h00fa;
    status_is(1'b1, 1'b1, 1'b0, 1'b0);
    // undefined place and foreign address
    write_chk(8'h20, 8'hff);
    read_n(8'h20, 1, 24'h0);
    host.write_reg(7'h40, `CDR_SUB_OUTPUT, 8'h00, ok);
    check_bit("foreign ack", 1'b0, ok);
    check_ctrl("foreign write ignored", exp_c);
    // system reset by the 1-then-0 pair
    write_chk(`CDR_SUB_LOCK_RST, 8'h20);
    write_chk(`CDR_SUB_LOCK_RST, 8'h00);
    exp_c = '0;
    exp_c.signal_lost_pin = 1'b1;
    exp_c.clk_out_en = 1'b1;
    exp_c.data_out_en = 1'b1;
    check_ctrl("after system reset", exp_c);
    read_n(`CDR_SUB_FREQ_LOW, 3, 24'h0);
    report_and_stop();
  end
endmodule : cdr_i2c_register_port_test
`default_nettype wire
